//--- vch_cfg.svh
// offsets, field positions, reset values and timing counts for the vc slice
`ifndef VCH_CFG_SVH
`define VCH_CFG_SVH
`define VCH_OFF_HDR0      12'h11c
`define VCH_OFF_HDR1      12'h120
`define VCH_OFF_HDR2      12'h124
`define VCH_OFF_HDR3      12'h128
`define VCH_OFF_CAPHDR    12'h140
`define VCH_OFF_PCAP1     12'h144
`define VCH_OFF_PCAP2     12'h148
`define VCH_OFF_PCTRL     12'h14c
`define VCH_OFF_TBLWR     12'h180
`define VCH_OFF_AUTOLOAD  12'h184
`define VCH_CAP_ID        16'h0002
`define VCH_CAP_VER       4'h1
`define VCH_NEXT_PTR      12'h20c
`define VCH_REFCLK_100NS  2'h0
`define VCH_ENTRY_4BIT    2'h2
`define VCH_ARB_CAP_ON    8'h03
`define VCH_ARB_CAP_OFF   8'h00
`define VCH_TBL_OFF_ON    8'h03
`define VCH_TBL_OFF_OFF   8'h00
`define VCH_SEL_MAX       3'h1
`define VCH_LOAD_TIME_NS  200
`define VCH_CLK_NS        20
`define VCH_LOAD_CYC      ((`VCH_LOAD_TIME_NS + `VCH_CLK_NS - 1) / `VCH_CLK_NS)
`define VCH_TBL_STATUS_BIT 16
`endif

//--- vch_pkg.sv
// types shared by the vc slice
package vch_pkg;
	typedef enum logic [1:0] {VCH_IDLE, VCH_LOADING} vch_load_e;
	typedef logic [31:0] vch_word_t;
endpackage

//--- vch_loader.sv
// table load sequencer: busy for a fixed count after a load command
`timescale 1ns/1ps
`include "vch_cfg.svh"
module vch_loader (
	input  wire logic clock,   // core clock
	input  wire logic rst_n,   // async reset, active low
	input  wire logic start,   // load command pulse
	output logic      busy,    // load in progress
	output logic      done     // one-cycle pulse at load end
);
	vch_pkg::vch_load_e state_reg;
	logic [7:0]         cnt_reg;
	wire last = (cnt_reg == 8'(`VCH_LOAD_CYC - 1));

	// count through the load; a new start while busy is absorbed
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= vch_pkg::VCH_IDLE;
			cnt_reg <= 8'h00;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state_reg)
				vch_pkg::VCH_IDLE: begin
					cnt_reg <= 8'h00;
					if (start) state_reg <= vch_pkg::VCH_LOADING;
				end
				vch_pkg::VCH_LOADING: begin
					cnt_reg <= cnt_reg + 8'h01;
					if (last) begin
						state_reg <= vch_pkg::VCH_IDLE;
						done <= 1'b1;
					end
				end
				default: state_reg <= vch_pkg::VCH_IDLE;
			endcase
		end
	end
	assign busy = (state_reg == vch_pkg::VCH_LOADING);
endmodule

//--- vch_regs.sv
// channel_capability_header, control and header log registers on apb
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "vch_cfg.svh"
module vch_regs (
	input  wire logic         clock,         // core clock 50 mhz
	input  wire logic         rst_n,         // ordinary reset, active low
	input  wire logic         por_n,         // power-on reset, active low
	input  wire logic         channel_extension_strap, // strap level
	input  wire logic         hdr_capture,   // capture header pulse
	input  wire logic [127:0] hdr_in,        // header, byte 0 in [31:24]
	input  wire logic         psel,          // apb select
	input  wire logic         penable,       // apb enable
	input  wire logic         pwrite,        // apb direction
	input  wire logic [11:0]  paddr,         // apb byte address
	input  wire logic [31:0]  pwdata,        // apb write data
	output logic [31:0]       prdata,        // apb read data
	output logic              pready,        // apb ready
	output logic              pslverr,       // apb error
	output logic              tbl_load_pulse, // apply table to arbiter
	output logic [2:0]        arb_select,    // active arbitration scheme
	output logic              tbl_loading    // load in progress
);
	logic [127:0] hdr_reg;
	logic [2:0]   ext_cnt_reg;
	logic [2:0]   lp_cnt_reg;
	logic [2:0]   sel_reg;
	logic         tbl_stat_reg;
	logic         strap_done_reg;
	logic         load_done;
	logic [31:0]  rdata_next;

	// decode on the access phase, except rd_setup on the setup phase
	wire acc     = psel & penable;
	wire wr      = acc & pwrite;
	wire rd      = acc & ~pwrite;
	wire rd_setup = psel & ~penable & ~pwrite;
	wire hit_c   = (paddr == `VCH_OFF_PCTRL);
	wire hit_t   = (paddr == `VCH_OFF_TBLWR);
	wire hit_a   = (paddr == `VCH_OFF_AUTOLOAD);
	wire mapped  = (paddr == `VCH_OFF_HDR0) | (paddr == `VCH_OFF_HDR1) |
		(paddr == `VCH_OFF_HDR2) | (paddr == `VCH_OFF_HDR3) |
		(paddr == `VCH_OFF_CAPHDR) | (paddr == `VCH_OFF_PCAP1) |
		(paddr == `VCH_OFF_PCAP2) | hit_c | hit_t | hit_a;
	wire ext0    = ext_cnt_reg[0];

	// read-only words, built combinationally from constants and state
	wire [31:0] cap_hdr = {`VCH_NEXT_PTR, `VCH_CAP_VER, `VCH_CAP_ID};
	wire [31:0] pcap1 = {20'h00000, `VCH_ENTRY_4BIT, `VCH_REFCLK_100NS,
		1'b0, lp_cnt_reg, 1'b0, ext_cnt_reg};
	wire [7:0] arb_cap = ext0 ? `VCH_ARB_CAP_ON : `VCH_ARB_CAP_OFF;
	wire [7:0] tbl_off = ext0 ? `VCH_TBL_OFF_ON : `VCH_TBL_OFF_OFF;
	wire [31:0] pcap2 = {tbl_off, 16'h0000, arb_cap};
	// load bit always reads zero; status in bit 16
	wire [31:0] pctrl = {15'h0000, tbl_stat_reg, 12'h000, sel_reg, 1'b0};
	// the capability is valid only with a low-priority group
	wire arb_cap_valid = (lp_cnt_reg != 3'h0);

	// fold illegal scheme codes to the default
	function automatic logic [2:0] legal_sel(input logic [2:0] v);
		legal_sel = (v > `VCH_SEL_MAX) ? 3'h0 : v;
	endfunction

	// header word n, first word at the lowest offset
	function automatic logic [31:0] hdr_word(input logic [127:0] h,
		input logic [1:0] n);
		hdr_word = h[32*n +: 32];
	endfunction

	// read mux; unmapped reads return zero
	always_comb begin
		case (paddr)
			`VCH_OFF_HDR0:   rdata_next = hdr_word(hdr_reg, 2'd0);
			`VCH_OFF_HDR1:   rdata_next = hdr_word(hdr_reg, 2'd1);
			`VCH_OFF_HDR2:   rdata_next = hdr_word(hdr_reg, 2'd2);
			`VCH_OFF_HDR3:   rdata_next = hdr_word(hdr_reg, 2'd3);
			`VCH_OFF_CAPHDR: rdata_next = cap_hdr;
			`VCH_OFF_PCAP1:  rdata_next = pcap1;
			`VCH_OFF_PCAP2:  rdata_next = pcap2;
			`VCH_OFF_PCTRL:  rdata_next = pctrl;
			`VCH_OFF_AUTOLOAD: rdata_next = {31'h0, arb_cap_valid};
			default:         rdata_next = 32'h00000000;
		endcase
	end

	// zero-wait slave; unmapped addresses flag an error
	assign pready  = 1'b1;
	assign pslverr = acc & ~mapped;

	// read data loaded in setup, so it stands through the zero-wait access
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) prdata <= 32'h00000000;
		else if (rd_setup) prdata <= rdata_next;
	end

	// header log only follows the power-on reset
	always_ff @(posedge clock or negedge por_n) begin
		if (!por_n) hdr_reg <= 128'h0;
		else if (hdr_capture) hdr_reg <= hdr_in;
	end

	// strap caught in the first clocked cycle after release
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ext_cnt_reg <= 3'h0;
			lp_cnt_reg <= 3'h0;
			strap_done_reg <= 1'b0;
		end else if (!strap_done_reg) begin
			ext_cnt_reg <= {2'b00, channel_extension_strap};
			strap_done_reg <= 1'b1;
		end else if (wr && hit_a) begin
			// autoload path stands in for the serial-memory loader
			ext_cnt_reg <= pwdata[2:0];
			lp_cnt_reg <= pwdata[6:4];
		end
	end

	// control: scheme select, reserved bits dropped
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) sel_reg <= 3'h0;
		else if (wr && hit_c) sel_reg <= legal_sel(pwdata[3:1]);
	end

	// load command is a pulse, never stored
	assign tbl_load_pulse = wr & hit_c & pwdata[0];
	assign arb_select = sel_reg;

	// status: table write sets, load end clears; set wins
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) tbl_stat_reg <= 1'b0;
		else if (wr && hit_t) tbl_stat_reg <= 1'b1;
		else if (load_done) tbl_stat_reg <= 1'b0;
	end

	vch_loader u_loader (
		.clock (clock),
		.rst_n (rst_n),
		.start (tbl_load_pulse),
		.busy  (tbl_loading),
		.done  (load_done)
	);

	// assertions
	property p_capid;
		@(posedge clock) disable iff (!rst_n)
		rd && paddr == `VCH_OFF_CAPHDR |-> prdata == 32'h20c10002;
	endproperty
	a_capid: assert property (p_capid) else $error("cap header wrong");

	property p_ver;
		@(posedge clock) disable iff (!rst_n)
		rd && paddr == `VCH_OFF_CAPHDR |-> prdata[19:16] == 4'h1;
	endproperty
	a_ver: assert property (p_ver) else $error("version wrong");

	property p_next;
		@(posedge clock) disable iff (!rst_n)
		rd && paddr == `VCH_OFF_CAPHDR |-> prdata[31:20] == 12'h20c;
	endproperty
	a_next: assert property (p_next) else $error("next ptr wrong");

	property p_pcap2;
		@(posedge clock) disable iff (!rst_n)
		rd && paddr == `VCH_OFF_PCAP2 |->
			prdata == (ext_cnt_reg[0] ? 32'h03000003 : 32'h0);
	endproperty
	a_pcap2: assert property (p_pcap2) else $error("pcap2 wrong");

	property p_pcap1;
		@(posedge clock) disable iff (!rst_n)
		rd && paddr == `VCH_OFF_PCAP1 |->
			prdata[11:8] == 4'h8 && prdata[31:12] == 20'h0;
	endproperty
	a_pcap1: assert property (p_pcap1) else $error("pcap1 fixed wrong");

	property p_ctrl0;
		@(posedge clock) disable iff (!rst_n)
		rd && paddr == `VCH_OFF_PCTRL |-> prdata[0] == 1'b0;
	endproperty
	a_ctrl0: assert property (p_ctrl0) else $error("load bit read one");

	property p_sel;
		@(posedge clock) disable iff (!rst_n)
		wr && hit_c && pwdata[3:1] > 3'h1 |=> sel_reg == 3'h0;
	endproperty
	a_sel: assert property (p_sel) else $error("illegal select kept");

	property p_stat;
		@(posedge clock) disable iff (!rst_n)
		wr && hit_t |=> tbl_stat_reg;
	endproperty
	a_stat: assert property (p_stat) else $error("status not set");

	// busy run length, counted here since a long repetition is not unrolled
	logic [7:0] busy_run_reg;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) busy_run_reg <= 8'h00;
		else if (tbl_loading) busy_run_reg <= busy_run_reg + 8'h01;
		else busy_run_reg <= 8'h00;
	end

	// a load command starts the sequencer on the next edge
	property p_load_start;
		@(posedge clock) disable iff (!rst_n)
		tbl_load_pulse && !tbl_loading |=> tbl_loading;
	endproperty
	a_load_start: assert property (p_load_start)
		else $error("load did not start");

	// busy stands exactly the load count, never longer
	property p_load_len;
		@(posedge clock) disable iff (!rst_n)
		$fell(tbl_loading) |-> busy_run_reg == 8'(`VCH_LOAD_CYC);
	endproperty
	a_load_len: assert property (p_load_len)
		else $error("load length");

	property p_load_max;
		@(posedge clock) disable iff (!rst_n)
		(busy_run_reg <= 8'(`VCH_LOAD_CYC));
	endproperty
	a_load_max: assert property (p_load_max)
		else $error("load overran");

	// a finished load clears the status unless a table write meets it
	property p_stat_clr;
		@(posedge clock) disable iff (!rst_n)
		load_done && !(wr && hit_t) |=> !tbl_stat_reg;
	endproperty
	a_stat_clr: assert property (p_stat_clr)
		else $error("status not cleared");

	// rst_n in the antecedent keeps the release edge itself out
	property p_strap;
		@(posedge clock) disable iff (!rst_n)
		rst_n && !strap_done_reg |=>
			ext_cnt_reg == {2'b00, $past(channel_extension_strap)};
	endproperty
	a_strap: assert property (p_strap) else $error("strap not caught");

	// the header log ignores ordinary resets and changes only on capture
	property p_hdr_sticky;
		@(posedge clock) disable iff (!por_n)
		!hdr_capture |=> $stable(hdr_reg);
	endproperty
	a_hdr_sticky: assert property (p_hdr_sticky)
		else $error("header log changed");

	property p_hdr_load;
		@(posedge clock) disable iff (!por_n)
		hdr_capture |=> hdr_reg == $past(hdr_in);
	endproperty
	a_hdr_load: assert property (p_hdr_load)
		else $error("header not captured");

	// first word of the header at the lowest offset
	property p_hdr_first;
		@(posedge clock) disable iff (!rst_n)
		rd && paddr == `VCH_OFF_HDR0 |-> prdata == hdr_reg[31:0];
	endproperty
	a_hdr_first: assert property (p_hdr_first)
		else $error("header word order");

	// low-priority count comes out of reset at zero
	property p_lp_reset;
		@(posedge clock) disable iff (!rst_n)
		rst_n && !strap_done_reg |=> lp_cnt_reg == 3'h0;
	endproperty
	a_lp_reset: assert property (p_lp_reset)
		else $error("low-priority count not zero");

	// fixed fields, reserved bits and table offset of the capability words
	property p_refclk;
		@(posedge clock) disable iff (!rst_n)
		rd && paddr == `VCH_OFF_PCAP1 |-> prdata[9:8] == 2'h0;
	endproperty
	a_refclk: assert property (p_refclk)
		else $error("reference clock code");

	property p_pcap1_rsv;
		@(posedge clock) disable iff (!rst_n)
		rd && paddr == `VCH_OFF_PCAP1 |-> !prdata[3] && !prdata[7];
	endproperty
	a_pcap1_rsv: assert property (p_pcap1_rsv)
		else $error("pcap1 reserved bit set");

	property p_tbl_off;
		@(posedge clock) disable iff (!rst_n)
		rd && paddr == `VCH_OFF_PCAP2 |->
			prdata[31:24] == (ext_cnt_reg[0] ? 8'h03 : 8'h00);
	endproperty
	a_tbl_off: assert property (p_tbl_off)
		else $error("table offset wrong");

	// validity flag follows the low-priority group size
	property p_valid;
		@(posedge clock) disable iff (!rst_n)
		rd && paddr == `VCH_OFF_AUTOLOAD |->
			prdata[0] == (lp_cnt_reg != 3'h0);
	endproperty
	a_valid: assert property (p_valid)
		else $error("capability valid flag");

	property p_ctrl_rsv;
		@(posedge clock) disable iff (!rst_n)
		rd && paddr == `VCH_OFF_PCTRL |->
			prdata[15:4] == 12'h000 && prdata[31:17] == 15'h0000;
	endproperty
	a_ctrl_rsv: assert property (p_ctrl_rsv)
		else $error("control reserved bit set");

	// unmapped reads never leak stale data
	property p_unmapped;
		@(posedge clock) disable iff (!rst_n)
		rd && !mapped |-> prdata == 32'h00000000;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");

	// legal scheme codes are kept as written
	property p_sel_keep;
		@(posedge clock) disable iff (!rst_n)
		wr && hit_c && (pwdata[3:1] <= 3'h1) |=>
			sel_reg == $past(pwdata[3:1]);
	endproperty
	a_sel_keep: assert property (p_sel_keep)
		else $error("legal select lost");

	c_load: cover property (@(posedge clock) disable iff (!rst_n) load_done);
	c_err: cover property (@(posedge clock) disable iff (!rst_n) pslverr);
	c_cap: cover property (@(posedge clock) disable iff (!rst_n)
		rd && paddr == `VCH_OFF_PCAP2 && ext_cnt_reg[0]);
	c_sel: cover property (@(posedge clock) disable iff (!rst_n)
		wr && hit_c && pwdata[3:1] > 3'h1);
	c_hdr: cover property (@(posedge clock) disable iff (!por_n) hdr_capture);
endmodule

//--- vch_tb.sv
// self-checking apb bench for the channel_capability_header and header log slice
`timescale 1ns/1ps
`include "vch_cfg.svh"
module testbench;
	logic         clock = 1'b0;          // core clock, 20 ns
	logic         rst_n = 1'b0;          // ordinary reset
	logic         por_n = 1'b0;          // power-on reset
	logic         strap = 1'b1;          // channel extension strap
	logic         hdr_capture = 1'b0;    // header capture pulse
	logic [127:0] hdr_in = 128'h0;       // header to capture
	logic         psel = 1'b0;           // apb select
	logic         penable = 1'b0;        // apb enable
	logic         pwrite = 1'b0;         // apb direction
	logic [11:0]  paddr = 12'h0;         // apb address
	logic [31:0]  pwdata = 32'h0;        // apb write data
	logic [31:0]  prdata;                // apb read data
	logic         pready;                // apb ready
	logic         pslverr;               // apb error
	logic         tbl_load_pulse;        // table apply pulse
	logic [2:0]   arb_select;            // active scheme
	logic         tbl_loading;           // load busy
	logic         err_seen;              // pslverr at last access edge
	logic         pulse_seen;            // load pulse at last access edge
	logic [31:0]  rd;                    // last read data
	int           bad_count = 0;
	int           checks_done = 0;
	int           n;

	vch_regs uut (.clock(clock), .rst_n(rst_n), .por_n(por_n),
		.channel_extension_strap(strap), .hdr_capture(hdr_capture),
		.hdr_in(hdr_in), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tbl_load_pulse(tbl_load_pulse),
		.arb_select(arb_select), .tbl_loading(tbl_loading));

	// free-running core clock
	always #10 clock = ~clock;

	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// one apb transfer; flags and read data caught at the access edge
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		err_seen = pslverr;
		pulse_seen = tbl_load_pulse;
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask

	// header log words: first word lowest, read word by word
	task automatic hdr_chk(input logic [127:0] exp);
		for (int i = 0; i < 4; i++) begin
			rd_chk(12'(`VCH_OFF_HDR0 + 4 * i), exp[32 * i +: 32]);
		end
	endtask

	// strap is held through reset so the first edge after release sees it
	task automatic do_reset(input logic por, input logic s);
		@(posedge clock);
		rst_n <= 1'b0;
		por_n <= ~por;
		strap <= s;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		por_n <= 1'b1;
		repeat (2) @(posedge clock);
	endtask

	// main sequence
	initial begin
		do_reset(1'b1, 1'b1);
		rd_chk(`VCH_OFF_CAPHDR, 32'h20c1_0002);
		apb(1'b1, `VCH_OFF_CAPHDR, 32'hffff_ffff);
		rd_chk(`VCH_OFF_CAPHDR, 32'h20c1_0002);
		rd_chk(`VCH_OFF_PCAP1, 32'h0000_0801);
		apb(1'b1, `VCH_OFF_PCAP1, 32'hffff_ffff);
		rd_chk(`VCH_OFF_PCAP1, 32'h0000_0801);
		rd_chk(`VCH_OFF_PCAP2, 32'h0300_0003);
		check({31'h0, err_seen}, 32'h0);
		rd_chk(`VCH_OFF_PCTRL, 32'h0);
		// every select code, reserved bits 15:4 written high, load bit low
		for (int s = 0; s < 8; s++) begin
			apb(1'b1, `VCH_OFF_PCTRL, 32'hfff0 | 32'(s << 1));
			check({31'h0, pulse_seen}, 32'h0);
			n = (s <= `VCH_SEL_MAX) ? s : 0;
			rd_chk(`VCH_OFF_PCTRL, 32'(n << 1));
			check({29'h0, arb_select}, 32'(n));
		end
		apb(1'b1, `VCH_OFF_TBLWR, 32'h5);
		rd_chk(`VCH_OFF_PCTRL, 32'h0001_0000);
		apb(1'b1, `VCH_OFF_PCTRL, 32'h3);
		check({31'h0, pulse_seen}, 32'h1);
		n = 1;
		while (tbl_loading === 1'b1 && n < 40) begin
			@(posedge clock);
			#1 n++;
		end
		check(32'(n), `VCH_LOAD_CYC);
		rd_chk(`VCH_OFF_PCTRL, 32'h2);
		// capture a header, then survive an ordinary reset only
		@(posedge clock);
		hdr_in <= 128'hf0e1d2c3_b4a59687_78695a4b_3c2d1e0f;
		hdr_capture <= 1'b1;
		@(posedge clock);
		hdr_capture <= 1'b0;
		hdr_chk(128'hf0e1d2c3_b4a59687_78695a4b_3c2d1e0f);
		apb(1'b1, `VCH_OFF_HDR0, 32'h0);
		do_reset(1'b0, 1'b1);
		hdr_chk(128'hf0e1d2c3_b4a59687_78695a4b_3c2d1e0f);
		do_reset(1'b1, 1'b0);
		hdr_chk(128'h0);
		rd_chk(`VCH_OFF_PCAP1, 32'h0000_0800);
		rd_chk(`VCH_OFF_PCAP2, 32'h0);
		// autoload overrides both counts
		apb(1'b1, `VCH_OFF_AUTOLOAD, 32'h21);
		rd_chk(`VCH_OFF_PCAP1, 32'h0000_0821);
		rd_chk(`VCH_OFF_PCAP2, 32'h0300_0003);
		apb(1'b0, `VCH_OFF_AUTOLOAD, 32'h0);
		check(rd & 32'h1, 32'h1);
		apb(1'b1, `VCH_OFF_AUTOLOAD, 32'h01);
		apb(1'b0, `VCH_OFF_AUTOLOAD, 32'h0);
		check(rd & 32'h1, 32'h0);
		// unmapped place: error flagged, read returns zero
		apb(1'b1, 12'h1f0, 32'hffff_ffff);
		check({31'h0, err_seen}, 32'h1);
		rd_chk(12'h1f0, 32'h0);
		check({31'h0, err_seen}, 32'h1);
		give_verdict();
	end

	// watchdog: the whole sequence needs well under 10000 cycles
	initial begin
		repeat (10000) @(posedge clock);
		bad_count++;
		$display("ERROR %0t: run did not finish in time", $time);
		give_verdict();
	end
endmodule
